// ### isto_axis.sv
// One axis: APB registers, pulse pacing, target rewrite and position-start gating.
// Assumes an APB master, a motor driver on pulseOut and sibling axes' pulse flags.
//////////////////////////////////////////////////////////////////////////////
module isto_axis (
  input wire logic clock, // 20 MHz reference clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire logic [2:0] otherPacedPulse, // Paced pulses from other axes this cycle
  input wire logic comparatorFiveMatch, // Comparator five match, same clock
  input wire logic positionStartInput, // External position-start pin
  output logic pulseOut, // Command pulse to driver
  output logic dirOut, // Direction to driver, 1 = minus
  output logic pacedPulse // This axis pulses and is paced
);
  import isto_pkg::*;

  function automatic logic rewritable(input logic [7:0] m);
    return (m == MOD_INC) || (m == MOD_ABS1) || (m == MOD_ABS2) || (m == MOD_REL);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] mode_reg, modeNext, target_reg, speed_reg, env_reg;
  logic [31:0] preMode_reg, preTarget_reg, preSpeed_reg;
  logic [31:0] remain_reg, remainNext, done_reg, curSpeed_reg;
  logic [31:0] interval_reg, intervalNext;
  logic rejected_reg, dir_reg, counting_reg, pulse_reg, sync1_reg, sync2_reg;
  isto_phase_t phase_reg, phaseNext;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_ENV);
  wire cmdWr = wr && (paddr == ADDR_CMD);
  wire [7:0] cmd = pwdata[7:0];
  wire targetWr = wr && (paddr == ADDR_TARGET);
  wire statusRd = rd && (paddr == ADDR_STATUS);
  wire [7:0] opMode = mode_reg[MODE_OP_LSB +: 8];
  wire running = (phase_reg != PH_IDLE);
  wire finalPulse = pulse_reg && counting_reg && (remain_reg == 32'h0000_0001);
  wire preShift = (cmdWr && (cmd == CMD_PRESHIFT)) || comparatorFiveMatch;
  wire pcsOn = sync2_reg || (cmdWr && (cmd == CMD_PCS_SUB));

  // Accept only while moving, never on the final pulse cycle
  wire accept = targetWr && running && rewritable(opMode) && !finalPulse;
  wire reject = targetWr && !accept;
  // Incremental: new remaining measured from start point
  wire [31:0] newRemain = pwdata - done_reg;
  wire passed = (pwdata <= done_reg);
  wire farther = pwdata > target_reg;

  // Pacing count: only paced axes; four axes get the three-axis factor
  wire paceMode = (opMode == MOD_LIN1A) || (opMode == MOD_LIN1B) ||
                  (opMode == MOD_CIRA) || (opMode == MOD_CIRB);
  wire paceOn = mode_reg[MODE_PACE_BIT] && paceMode;
  wire [2:0] nPaced = {2'b00, pacedPulse} + {2'b00, otherPacedPulse[0]} +
                      {2'b00, otherPacedPulse[1]} + {2'b00, otherPacedPulse[2]};
  wire [9:0] kFac = (!pacedPulse || nPaced < 3'd2) ? K_ONE :
                    (nPaced == 3'd2) ? K_SQRT2 : K_SQRT3;
  wire [41:0] stretched = {10'h000, curSpeed_reg} * {32'h0000_0000, kFac};

  //////////////////////////////////////////////////////////////////////////////
  // Phase and remaining count
  always_comb begin
    phaseNext = phase_reg;
    remainNext = remain_reg;
    modeNext = mode_reg;
    if (cmdWr && cmd == CMD_START && !running) begin
      phaseNext = PH_ACCEL;
      remainNext = target_reg;
    end else if (cmdWr && cmd == CMD_STOP) begin
      phaseNext = PH_IDLE;
    end else if (finalPulse) begin
      phaseNext = PH_IDLE;
      remainNext = 32'h0000_0000;
    end else begin
      if (pulse_reg && counting_reg && remain_reg != 32'h0000_0000)
        remainNext = remain_reg - 32'h0000_0001;
      case (phase_reg)
        PH_ACCEL: if (curSpeed_reg <= speed_reg || curSpeed_reg <= MIN_SPEED) phaseNext = PH_CONST;
        // Auto slow-down point; exact in circles only at quarter-turn ends
        PH_CONST:
          if (counting_reg && remain_reg <= (curSpeed_reg >> 4)) phaseNext = PH_DECEL;
        PH_DECEL: if (curSpeed_reg >= RESET_SPEED) phaseNext = PH_FL_CONST;
        PH_REV_DECEL: if (curSpeed_reg >= RESET_SPEED) phaseNext = PH_ACCEL;
        PH_FL_CONST, PH_IDLE: ;
        default: phaseNext = PH_IDLE;
      endcase
    end
    if (accept) begin
      remainNext = passed ? (done_reg - pwdata) : newRemain;
      if (passed || !farther) begin
        // Short or passed: ramp down to start speed, then accelerate; passed reverses at once
        phaseNext = PH_REV_DECEL;
      end else if (phase_reg == PH_REV_DECEL) begin
        phaseNext = mode_reg[MODE_SDP_BIT] ? PH_REV_DECEL : PH_FL_CONST;
      end else if (phase_reg == PH_DECEL) begin
        phaseNext = PH_ACCEL;
      end // Accel or constant keep their pattern
    end
    if (preShift) begin
      modeNext = preMode_reg;
      remainNext = preTarget_reg;
    end
  end

  // Interval between pulses from speed, stretched when pacing
  always_comb begin
    intervalNext = interval_reg - 32'h0000_0001;
    // Reload one short: the pulse cycle itself counts toward the period
    if (pulse_reg)
      intervalNext = (paceOn ? stretched[39:8] : curSpeed_reg) - 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= 32'h0000_0000;
      target_reg <= 32'h0000_0000;
      speed_reg <= RESET_SPEED;
      env_reg <= 32'h0000_0000;
      preMode_reg <= 32'h0000_0000;
      preTarget_reg <= 32'h0000_0000;
      preSpeed_reg <= RESET_SPEED;
    end else begin
      mode_reg <= (wr && paddr == ADDR_MODE) ? pwdata : modeNext;
      if (wr && paddr == ADDR_TARGET) target_reg <= pwdata;
      else if (preShift) target_reg <= preTarget_reg;
      if (wr && paddr == ADDR_SPEED) speed_reg <= pwdata;
      else if (preShift) speed_reg <= preSpeed_reg;
      if (wr && paddr == ADDR_ENV) env_reg <= pwdata;
      if (wr && paddr == ADDR_PRE_MODE) preMode_reg <= pwdata;
      if (wr && paddr == ADDR_PRE_TARGET) preTarget_reg <= pwdata;
      if (wr && paddr == ADDR_PRE_SPEED) preSpeed_reg <= pwdata;
    end
  end

  // Rejected flag: set wins over either clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      rejected_reg <= 1'b0;
    else if (reject)
      rejected_reg <= 1'b1;
    else if ((cmdWr && cmd == CMD_CLR_REJ) || (statusRd && !env_reg[ENV_RCD_BIT]))
      rejected_reg <= 1'b0;
  end

  // Two-stage synchroniser; read at the start, while running and by status
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= positionStartInput;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= PH_IDLE;
      remain_reg <= 32'h0000_0000;
      done_reg <= 32'h0000_0000;
      counting_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      phase_reg <= phaseNext;
      remain_reg <= remainNext;
      if (cmdWr && cmd == CMD_START && !running) begin
        done_reg <= 32'h0000_0000;
        counting_reg <= !mode_reg[MODE_PCS_BIT] || sync2_reg;
      end else begin
        if (pulse_reg) done_reg <= dir_reg ? done_reg - 32'h0000_0001 : done_reg + 32'h0000_0001;
        if (running && pcsOn) counting_reg <= 1'b1;
      end
      if (cmdWr && cmd == CMD_START && !running) dir_reg <= 1'b0;
      else if (accept && passed) dir_reg <= !dir_reg;
    end
  end

  // Speed ramp and pulse timer; larger value means slower pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      curSpeed_reg <= RESET_SPEED;
      interval_reg <= RESET_SPEED;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= running && (interval_reg == 32'h0000_0001);
      interval_reg <= running ? intervalNext : RESET_SPEED;
      if (!running) curSpeed_reg <= RESET_SPEED;
      else if (pulse_reg && phase_reg == PH_ACCEL && curSpeed_reg > MIN_SPEED &&
               curSpeed_reg > speed_reg)
        curSpeed_reg <= curSpeed_reg - 32'h0000_0001;
      else if (pulse_reg && (phase_reg == PH_DECEL || phase_reg == PH_REV_DECEL) &&
               curSpeed_reg < RESET_SPEED)
        curSpeed_reg <= curSpeed_reg + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  wire [31:0] statusWord = {22'h000000, dir_reg, sync2_reg, 3'b000, rejected_reg,
                            2'b00, running, 1'b0};
  always_comb begin
    case (paddr)
      ADDR_MODE: prdata = mode_reg;
      ADDR_TARGET: prdata = target_reg;
      ADDR_SPEED: prdata = speed_reg;
      ADDR_STATUS: prdata = statusWord;
      ADDR_REMAIN: prdata = remain_reg;
      ADDR_PRE_MODE: prdata = preMode_reg;
      ADDR_PRE_TARGET: prdata = preTarget_reg;
      ADDR_PRE_SPEED: prdata = preSpeed_reg;
      ADDR_ENV: prdata = env_reg;
      default: prdata = 32'h0000_0000;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign pulseOut = pulse_reg;
  assign dirOut = dir_reg;
  assign pacedPulse = pulse_reg && paceOn;
endmodule

// ### isto_axis_chk.sv
// Concurrent checks on the axis ports: pacing stretch and the rejected flag.
// Assumes zero-wait APB and a well-formed master on the register bus.
module isto_axis_chk
  import isto_pkg::*;
(
  input wire logic clock, // Reference clock
  input wire logic rstn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [2:0] otherPacedPulse, // Sibling paced pulses
  input wire logic comparatorFiveMatch, // Comparator five match
  input wire logic positionStartInput, // Position-start pin
  input wire logic pulseOut, // Step pulse
  input wire logic dirOut, // Direction
  input wire logic pacedPulse // Paced step
);
  logic envRcd;
  logic [7:0] modeOp;
  wire acc = psel && penable;
  wire rdStatus = acc && !pwrite && paddr == ADDR_STATUS;
  wire wrTarget = acc && pwrite && paddr == ADDR_TARGET;
  wire wrClear = acc && pwrite && paddr == ADDR_CMD && pwdata[7:0] == CMD_CLR_REJ;
  wire wrEnv = acc && pwrite && paddr == ADDR_ENV;
  wire wrMode = acc && pwrite && paddr == ADDR_MODE;
  // Shadow only tracks direct writes; a mode loaded by a pre-shift is not seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      envRcd <= 1'b0;
      modeOp <= 8'h00;
    end else begin
      if (wrEnv) envRcd <= pwdata[ENV_RCD_BIT];
      if (wrMode) modeOp <= pwdata[7:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_paced_is_pulse: assert property (pacedPulse |-> pulseOut)
    else $error("paced flag without a pulse");
  a_stretch_root2: assert property (pacedPulse && $countones(otherPacedPulse) == 1
    |=> !pulseOut [*4]) else $error("two-axis interval not stretched");
  a_stretch_root3: assert property (pacedPulse && $countones(otherPacedPulse) == 2
    |=> !pulseOut [*5]) else $error("three-axis interval not stretched");
  a_stretch_four: assert property (pacedPulse && otherPacedPulse == 3'h7
    |=> !pulseOut [*5]) else $error("four-axis interval not stretched");
  a_lin2_unpaced: assert property ((modeOp == 8'h62 || modeOp == 8'h63) |-> !pacedPulse)
    else $error("pacing active in linear type two");
  a_reject_idle: assert property (wrTarget ##[2:3] (rdStatus && !prdata[ST_RUN_BIT])
    |-> prdata[ST_REJ_BIT]) else $error("idle target write not flagged");
  a_read_clears: assert property (rdStatus && !envRcd ##[2:3] rdStatus
    |-> !prdata[ST_REJ_BIT]) else $error("status read did not clear flag");
  a_cmd_clears: assert property (wrClear ##[2:3] rdStatus |-> !prdata[ST_REJ_BIT])
    else $error("clear command did not clear flag");
endmodule

bind isto_axis isto_axis_chk chk (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .otherPacedPulse(otherPacedPulse), .comparatorFiveMatch(comparatorFiveMatch),
  .positionStartInput(positionStartInput), .pulseOut(pulseOut), .dirOut(dirOut),
  .pacedPulse(pacedPulse));

// ### isto_drv_model.sv
// Motor driver model: counts steps and net position from pulse and direction.
// Assumes pulses are one clock wide on the reference clock.
module isto_drv_model (
  input wire logic clock, // Reference clock
  input wire logic rstn, // Reset, active low
  input wire logic pulseOut, // Step pulse
  input wire logic dirOut, // 1 = minus
  output int pulses, // Steps seen
  output int pos, // Net position
  output logic sawRev // Minus step seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulses <= 0;
      pos <= 0;
      sawRev <= 1'b0;
    end else if (pulseOut) begin
      pulses <= pulses + 1;
      pos <= dirOut ? pos - 1 : pos + 1;
      sawRev <= sawRev | dirOut;
    end
  end
endmodule

// ### isto_pkg.sv
// Package for the per-axis interpolation pacing and target override block.
// Assumes a single 20 MHz reference clock and an APB master on the host side.
package isto_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_SPEED = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_REMAIN = 8'h14;
  localparam logic [7:0] ADDR_PRE_MODE = 8'h18;
  localparam logic [7:0] ADDR_PRE_TARGET = 8'h1C;
  localparam logic [7:0] ADDR_PRE_SPEED = 8'h20;
  localparam logic [7:0] ADDR_ENV = 8'h24;
  // Mode and environment register fields
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_SDP_BIT = 8;
  localparam int MODE_PACE_BIT = 9;
  localparam int MODE_PCS_BIT = 14;
  localparam int ENV_RCD_BIT = 0;
  // Operation mode codes
  localparam logic [7:0] MOD_INC = 8'h41;
  localparam logic [7:0] MOD_ABS1 = 8'h42;
  localparam logic [7:0] MOD_ABS2 = 8'h43;
  localparam logic [7:0] MOD_REL = 8'h47;
  localparam logic [7:0] MOD_LIN1A = 8'h60;
  localparam logic [7:0] MOD_LIN1B = 8'h61;
  localparam logic [7:0] MOD_CIRA = 8'h64;
  localparam logic [7:0] MOD_CIRB = 8'h65;
  // Commands
  localparam logic [7:0] CMD_START = 8'h51;
  localparam logic [7:0] CMD_STOP = 8'h49;
  localparam logic [7:0] CMD_PRESHIFT = 8'h2B;
  localparam logic [7:0] CMD_CLR_REJ = 8'h2E;
  localparam logic [7:0] CMD_PCS_SUB = 8'h28;
  // Status bits
  localparam int ST_RUN_BIT = 1;
  localparam int ST_REJ_BIT = 4;
  localparam int ST_PCS_BIT = 8;
  localparam int ST_DIR_BIT = 9;
  // Pacing: scaled interval factors, 256 = 1.0
  localparam logic [9:0] K_ONE = 10'h100;
  localparam logic [9:0] K_SQRT2 = 10'h16A;
  localparam logic [9:0] K_SQRT3 = 10'h1BB;
  localparam logic [31:0] RESET_SPEED = 32'h0000_0064;
  localparam logic [31:0] MIN_SPEED = 32'h0000_0004;
  typedef enum logic [2:0] {
    PH_IDLE, PH_ACCEL, PH_CONST, PH_DECEL, PH_REV_DECEL, PH_FL_CONST
  } isto_phase_t;
endpackage

// ### test_interp_speed_and_target_override.sv
// Testbench: drives the axis over APB, models the driver and judges results.
// Assumes zero-wait APB answers and the register map of the package.
module test_interp_speed_and_target_override;
  timeunit 1ns;
  timeprecision 1ps;
  import isto_pkg::*;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, cmpFive = 0, posStart = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, n;
  logic pready, pslverr, err, pulseOut, dirOut, pacedPulse, sawRev;
  logic [2:0] sibMask = 3'h0;
  wire [2:0] otherPacedPulse = pulseOut ? sibMask : 3'h0; // siblings pulse with this axis in any mode
  int bad_count = 0, samples_checked = 0, pulses, pos, i;
  initial forever #25 clock = ~clock;
  isto_axis uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .otherPacedPulse(otherPacedPulse), .comparatorFiveMatch(cmpFive),
    .positionStartInput(posStart), .pulseOut(pulseOut), .dirOut(dirOut), .pacedPulse(pacedPulse));
  isto_drv_model drv (.clock(clock), .rstn(rstn), .pulseOut(pulseOut), .dirOut(dirOut),
    .pulses(pulses), .pos(pos), .sawRev(sawRev));
  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo;
    bad_count++;
    $display("Error %0t: wait ran out", $time);
    results();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (k == 50) tmo();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic waitStop;
    for (i = 0; i < 9000; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (rd[ST_RUN_BIT] === 1'b0) break;
    end
    if (i == 9000) tmo();
  endtask
  task automatic startAxis(input logic [31:0] md, sp, tgt);
    apb(1'b1, ADDR_MODE, md);
    apb(1'b1, ADDR_SPEED, sp);
    apb(1'b1, ADDR_TARGET, tgt);
    apb(1'b1, ADDR_CMD, {24'h0, CMD_START});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk(rd, RESET_SPEED);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_reject;
    apb(1'b1, ADDR_TARGET, 32'h5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REJ_BIT], 1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REJ_BIT], 0);
    apb(1'b1, ADDR_ENV, 32'h1);
    apb(1'b1, ADDR_TARGET, 32'h5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REJ_BIT], 1);
    apb(1'b1, ADDR_CMD, {24'h0, CMD_CLR_REJ});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REJ_BIT], 0);
    apb(1'b1, ADDR_ENV, 32'h0);
  endtask
  // Rewrite lands just after the 50th step, long before the next one
  task automatic t_move(input logic [31:0] tgt, rew, input logic rev);
    int p0, q0;
    p0 = pulses;
    q0 = pos;
    startAxis({24'h0, MOD_INC}, 32'h28, tgt);
    for (i = 0; i < 20000 && pulses - p0 != 50; i++) @(posedge clock);
    if (i == 20000) tmo();
    apb(1'b1, ADDR_TARGET, rew);
    apb(1'b0, ADDR_REMAIN, 32'h0);
    if (rew > tgt) chk(rd, rew - 32'd50);
    waitStop();
    chk(32'(pos - q0), rew);
    chk(sawRev, rev);
  endtask
  task automatic t_pace;
    logic [7:0] md [7] = '{MOD_LIN1A, MOD_LIN1A, MOD_CIRB, MOD_LIN1B, MOD_LIN1A, 8'h62, MOD_LIN1A};
    logic [2:0] mk [7] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h7, 3'h1, 3'h1};
    logic [9:0] kt [7] = '{K_ONE, K_SQRT2, K_SQRT2, K_SQRT3, K_SQRT3, K_ONE, K_ONE};
    int p0;
    for (int e = 0; e < 7; e++) begin
      sibMask <= mk[e];
      p0 = pulses;
      startAxis({22'h0, e < 6, 1'b0, md[e]}, 32'h8, 32'd1000);
      // Ramp from start speed takes 92 steps; measure once at high speed
      for (i = 0; i < 20000 && pulses - p0 < 100; i++) @(posedge clock);
      if (i == 20000) tmo();
      for (i = 0; i < 100 && pulseOut !== 1'b1; i++) @(posedge clock);
      if (i == 100) tmo();
      n = 0;
      for (i = 0; i < 100 && (n == 0 || pulseOut !== 1'b1); i++) begin
        @(posedge clock);
        n++;
      end
      chk(n, (32'd8 * {22'h0, kt[e]}) >> 8);
      apb(1'b1, ADDR_CMD, {24'h0, CMD_STOP});
      waitStop();
    end
    sibMask <= 3'h0;
  endtask
  task automatic t_pcs;
    int p0;
    startAxis({16'h0, 2'b01, 6'h0, MOD_INC}, 32'h8, 32'd10);
    repeat (60) @(posedge clock);
    apb(1'b0, ADDR_REMAIN, 32'h0);
    chk(rd, 32'd10);
    posStart <= 1'b1;
    repeat (2) @(posedge clock);
    posStart <= 1'b0;
    waitStop();
    apb(1'b0, ADDR_REMAIN, 32'h0);
    chk(rd, 32'd0);
    // Substitute command instead of the pin: exactly the target is counted
    p0 = pulses;
    startAxis({16'h0, 2'b01, 6'h0, MOD_INC}, 32'h8, 32'd10);
    apb(1'b1, ADDR_CMD, {24'h0, CMD_PCS_SUB});
    waitStop();
    chk(32'(pulses - p0), 32'd10);
  endtask
  task automatic t_shift;
    apb(1'b1, ADDR_PRE_MODE, {24'h0, MOD_INC});
    apb(1'b1, ADDR_PRE_TARGET, 32'd30);
    apb(1'b1, ADDR_CMD, {24'h0, CMD_PRESHIFT});
    apb(1'b0, ADDR_REMAIN, 32'h0);
    chk(rd, 32'd30);
    apb(1'b1, ADDR_PRE_TARGET, 32'd7);
    @(posedge clock);
    cmpFive <= 1'b1;
    @(posedge clock);
    cmpFive <= 1'b0;
    apb(1'b0, ADDR_REMAIN, 32'h0);
    chk(rd, 32'd7);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_reject();
    t_move(32'd100, 32'd200, 1'b0);
    t_move(32'd100, 32'd20, 1'b1);
    t_pace();
    t_pcs();
    t_shift();
    results();
  end
endmodule
